// [shared/core_consts.svh]
// constants for the subtract / swap / pointer / stop execution block
// assumes: included by design and bench files by bare name
`ifndef CORE_CONSTS_SVH
`define CORE_CONSTS_SVH

// register indexes; byte address is four times the index
`define FLAGS_IDX 10'h0FC
`define WAP_IDX 10'h0FD
`define STD_LAST_IDX 10'h0FF
`define BANK_LAST_IDX 10'h1EF
`define CMD_IDX 10'h200
`define STAT_IDX 10'h201

// reset values
`define WAP_RST 8'h00
`define FLAGS_RST 8'h00
`define RESTART_PC 16'h000C

// flag bit positions inside the flags register
`define FLG_C 7
`define FLG_Z 6
`define FLG_S 5
`define FLG_V 4
`define FLG_D 3
`define FLG_H 2

// status register bit positions
`define STAT_STOP 0
`define STAT_BAD 1
`define STAT_UNFL 2

// command word byte lanes
`define CMD_OP_LSB 0
`define CMD_B1_LSB 8
`define CMD_B2_LSB 16

// opcodes
`define OP_SUB_RR 8'h22
`define OP_SUB_RIR 8'h23
`define OP_SUB_FF 8'h24
`define OP_SUB_FIF 8'h25
`define OP_SUB_FIM 8'h26
`define OP_SUB_IIM 8'h27
`define OP_SWAP_R 8'hF0
`define OP_SWAP_IR 8'hF1
`define OP_PTR_LOAD 8'h31
`define OP_STOP 8'h6F
`define OP_NOP 8'hFF

// high nibble marking a working register operand
`define WORK_NIB 4'hE

`endif

// [shared/core_pkg.sv]
// types shared by the execution block and its helpers
// assumes: constants come from core_consts.svh
package core_pkg;

    typedef enum logic [2:0]
    {
        X_IDLE,
        X_DEC,
        X_SRC,
        X_SRCI,
        X_DST,
        X_DSTI,
        X_EXEC
    } exec_state_type;

    typedef enum logic
    {
        ALU_SUB,
        ALU_SWAP
    } alu_op_type;

endpackage : core_pkg

// [shared/core_if.sv]
// carriers between the execution block, address mapper and alu
// assumes: all parties sit in the core_clk domain
`timescale 1ns/1ns

interface map_if;
    logic [7:0] addr;
    logic wok;
    logic [7:0] rp;
    logic [8:0] phys;
    modport user (output addr, output wok, output rp, input phys);
    modport mapper (input addr, input wok, input rp, output phys);
endinterface : map_if

interface alu_if;
    import core_pkg::*;
    alu_op_type op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] fin;
    logic [7:0] res;
    logic [7:0] fout;
    modport user (output op, output a, output b, output fin,
                  input res, input fout);
    modport unit (input op, input a, input b, input fin,
                  output res, output fout);
endinterface : alu_if

// [rtl/reg_map.sv]
// operand address to physical register index
// assumes: 256 standard registers then 15 banks of 16 at 256 upward
`timescale 1ns/1ns
`include "core_consts.svh"

module reg_map
    import core_pkg::*;
(
    map_if.mapper m
);

    function automatic logic [8:0] map_phys(input logic [7:0] a,
                                            input logic wok,
                                            input logic [7:0] rp);
        logic [3:0] bank;
        logic [3:0] bm1;
        bank = rp[3:0];
        bm1 = bank - 4'h1;
        map_phys = {1'b0, a};
        if (wok && a[7:4] == `WORK_NIB)
        begin
            if (bank != 4'h0)
                map_phys = {1'b1, bm1, a[3:0]};
            else
                map_phys = {1'b0, rp[7:4], a[3:0]};
        end
        else if (a[7:4] == 4'h0 && bank != 4'h0)
            // low sixteen standard locations give way to the bank
            map_phys = {1'b1, bm1, a[3:0]};
    endfunction : map_phys

    always_comb
    begin
        m.phys = map_phys(m.addr, m.wok, m.rp);
    end

endmodule : reg_map

// [rtl/alu_unit.sv]
// subtract and nibble exchange with flag generation
// assumes: purely combinational, caller registers the outputs
`timescale 1ns/1ns
`include "core_consts.svh"

module alu_unit
    import core_pkg::*;
(
    alu_if.unit u
);

    logic [8:0] full;
    logic [4:0] low;

    always_comb
    begin
        // two's complement add of the source
        full = {1'b0, u.a} + {1'b0, ~u.b} + 9'h001;
        low = {1'b0, u.a[3:0]} + {1'b0, ~u.b[3:0]} + 5'h01;
        u.fout = u.fin;
        if (u.op == ALU_SUB)
        begin
            u.res = full[7:0];
            u.fout[`FLG_C] = ~full[8];
            u.fout[`FLG_Z] = (full[7:0] == 8'h00);
            u.fout[`FLG_V] = (u.a[7] != u.b[7]) &&
                             (full[7] == u.b[7]);
            u.fout[`FLG_S] = full[7];
            u.fout[`FLG_D] = 1'b1;
            u.fout[`FLG_H] = ~low[4];
        end
        else
        begin
            u.res = {u.a[3:0], u.a[7:4]};
            // overflow is undefined here; it is left as it was
            u.fout[`FLG_Z] = (u.res == 8'h00);
            u.fout[`FLG_S] = u.res[7];
        end
    end

endmodule : alu_unit

// [rtl/exec_core.sv]
// execution block: subtract, nibble swap, pointer load, stop
// assumes: AHB-Lite single slave, one 50 MHz clock, sync reset
`timescale 1ns/1ns
`include "core_consts.svh"

// What this block does
// - pointer high nibble group, low nibble bank
// - nonzero bank: R0-R15 hit bank 00H-0FH
// - nonzero bank hides standard 00H-0FH
// - pointer F0H maps F0H-FFH as R0-R15
// - opcode 31 loads pointer, flags untouched
// - stop halts system clock and oscillator
// - only reset ends stop; restart at 000CH
// - subtract dst minus src into dst
// - opcode 22: dst high, src low nibble
// - opcode 24: source byte, then destination
// - opcode 26: destination byte, then immediate
// - carry set on borrow out of bit 7
// - zero set when result is zero
// - overflow on signed subtract overflow
// - sign from result, decimal flag forced one
// - half carry set on nibble borrow
// - high nibble E names a working register
// - swap exchanges nibbles of destination
// - swap sets zero and sign, keeps C D H
// - swap opcodes F0 direct, F1 indirect
module exec_core
    import core_pkg::*;
#(
    parameter int HADDR_W = 32
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // power control
    output logic sclk_en,
    output logic osc_en,
    output logic [15:0] restart_pc
);

    if (HADDR_W < 12)
        $error("exec_core: HADDR_W must be at least 12");

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] mem_r [0:495];
    exec_state_type xs_r, xs_nxt;
    logic [7:0] op_r, op_nxt, b1_r, b1_nxt, b2_r, b2_nxt;
    logic [7:0] src_r, src_nxt, dst_r, dst_nxt;
    logic sind_r, sind_nxt, dind_r, dind_nxt;
    logic [7:0] sv_r, sv_nxt, dv_r, dv_nxt;
    logic [8:0] dp_r, dp_nxt;
    logic [7:0] rp_r, rp_nxt, flags_r, flags_nxt;
    logic stop_r, stop_nxt, bad_r, bad_nxt, unfl_r, unfl_nxt;
    logic prev_nop_r, prev_nop_nxt;
    logic sclk_en_r, sclk_en_nxt, osc_en_r, osc_en_nxt;
    logic [15:0] restart_pc_r, restart_pc_nxt;
    logic pend_r, pend_nxt, bwr_r, bwr_nxt, bok_r, bok_nxt;
    logic [9:0] bidx_r, bidx_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic hready_r, hready_nxt;
    logic we;
    logic [8:0] wa;
    logic [7:0] wd;
    logic bus_fire;
    logic [7:0] sub_diff;

    map_if mp ();
    alu_if al ();

    reg_map u_map (.m(mp.mapper));
    alu_unit u_alu (.u(al.unit));

    // pointer and flags live in flops, not in the array
    function automatic logic [7:0] rd(input logic [8:0] p);
        if (p == `WAP_IDX)
            rd = rp_r;
        else if (p == `FLAGS_IDX)
            rd = flags_r;
        else
            rd = mem_r[p];
    endfunction : rd

    assign sub_diff = dv_r - sv_r;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        xs_nxt = xs_r;
        op_nxt = op_r;
        b1_nxt = b1_r;
        b2_nxt = b2_r;
        src_nxt = src_r;
        dst_nxt = dst_r;
        sind_nxt = sind_r;
        dind_nxt = dind_r;
        sv_nxt = sv_r;
        dv_nxt = dv_r;
        dp_nxt = dp_r;
        rp_nxt = rp_r;
        flags_nxt = flags_r;
        stop_nxt = stop_r;
        bad_nxt = bad_r;
        unfl_nxt = unfl_r;
        prev_nop_nxt = prev_nop_r;
        sclk_en_nxt = sclk_en_r;
        osc_en_nxt = osc_en_r;
        restart_pc_nxt = restart_pc_r;
        pend_nxt = pend_r;
        bwr_nxt = bwr_r;
        bok_nxt = bok_r;
        bidx_nxt = bidx_r;
        hrdata_nxt = hrdata_r;
        hready_nxt = hready_r;
        we = 1'b0;
        wa = 9'h000;
        wd = 8'h00;
        mp.addr = src_r;
        mp.wok = 1'b1;
        mp.rp = rp_r;
        al.op = (op_r[7:4] == 4'hF) ? ALU_SWAP : ALU_SUB;
        al.a = dv_r;
        al.b = sv_r;
        al.fin = flags_r;

        // bus: the data phase waits for the executer to go idle
        bus_fire = pend_r && (xs_r == X_IDLE);
        if (hsel && htrans[1] && hready)
        begin
            pend_nxt = 1'b1;
            hready_nxt = 1'b0;
            bwr_nxt = hwrite;
            bidx_nxt = haddr[11:2];
            bok_nxt = (hsize == 3'b010) && (haddr[1:0] == 2'b00) &&
                      (haddr >> 12 == '0);
        end
        if (bus_fire)
        begin
            pend_nxt = 1'b0;
            hready_nxt = 1'b1;
            hrdata_nxt = 32'h0000_0000;
            if (bok_r && bwr_r)
            begin
                if (bidx_r == `CMD_IDX)
                begin
                    // a halted core takes no further commands
                    if (!stop_r)
                    begin
                        op_nxt = hwdata[`CMD_OP_LSB +: 8];
                        b1_nxt = hwdata[`CMD_B1_LSB +: 8];
                        b2_nxt = hwdata[`CMD_B2_LSB +: 8];
                        bad_nxt = 1'b0;
                        xs_nxt = X_DEC;
                    end
                end
                else if (bidx_r <= `BANK_LAST_IDX)
                begin
                    we = 1'b1;
                    wa = bidx_r[8:0];
                    wd = hwdata[7:0];
                end
            end
            else if (bok_r)
            begin
                if (bidx_r == `STAT_IDX)
                begin
                    hrdata_nxt[`STAT_STOP] = stop_r;
                    hrdata_nxt[`STAT_BAD] = bad_r;
                    hrdata_nxt[`STAT_UNFL] = unfl_r;
                end
                else if (bidx_r <= `BANK_LAST_IDX)
                    hrdata_nxt = {24'h00_0000, rd(bidx_r[8:0])};
            end
        end

        // executer
        case (xs_r)
            X_IDLE:
            begin
                // a start made by the bus logic above must survive
            end
            X_DEC:
            begin
                prev_nop_nxt = (op_r == `OP_NOP);
                sind_nxt = op_r[0];
                dind_nxt = op_r[0];
                xs_nxt = X_IDLE;
                case (op_r)
                    `OP_SUB_RR, `OP_SUB_RIR:
                    begin
                        dst_nxt = {`WORK_NIB, b1_r[7:4]};
                        src_nxt = {`WORK_NIB, b1_r[3:0]};
                        dind_nxt = 1'b0;
                        xs_nxt = X_SRC;
                    end
                    `OP_SUB_FF, `OP_SUB_FIF:
                    begin
                        src_nxt = b1_r;
                        dst_nxt = b2_r;
                        dind_nxt = 1'b0;
                        xs_nxt = X_SRC;
                    end
                    `OP_SUB_FIM, `OP_SUB_IIM:
                    begin
                        dst_nxt = b1_r;
                        sv_nxt = b2_r;
                        xs_nxt = X_DST;
                    end
                    `OP_SWAP_R, `OP_SWAP_IR:
                    begin
                        dst_nxt = b1_r;
                        xs_nxt = X_DST;
                    end
                    `OP_PTR_LOAD:
                        rp_nxt = b1_r;
                    `OP_STOP:
                    begin
                        stop_nxt = 1'b1;
                        sclk_en_nxt = 1'b0;
                        osc_en_nxt = 1'b0;
                        // flagged when software skipped the flush
                        unfl_nxt = !prev_nop_r;
                    end
                    `OP_NOP:
                        xs_nxt = X_IDLE;
                    default:
                        bad_nxt = 1'b1;
                endcase
            end
            X_SRC:
            begin
                sv_nxt = rd(mp.phys);
                xs_nxt = sind_r ? X_SRCI : X_DST;
            end
            X_SRCI:
            begin
                mp.addr = sv_r;
                mp.wok = 1'b0;
                sv_nxt = rd(mp.phys);
                xs_nxt = X_DST;
            end
            X_DST:
            begin
                mp.addr = dst_r;
                dp_nxt = mp.phys;
                dv_nxt = rd(mp.phys);
                xs_nxt = dind_r ? X_DSTI : X_EXEC;
            end
            X_DSTI:
            begin
                mp.addr = dv_r;
                mp.wok = 1'b0;
                dp_nxt = mp.phys;
                dv_nxt = rd(mp.phys);
                xs_nxt = X_EXEC;
            end
            X_EXEC:
            begin
                // only the destination is written back
                we = 1'b1;
                wa = dp_r;
                wd = al.res;
                flags_nxt = al.fout;
                xs_nxt = X_IDLE;
            end
            default:
                xs_nxt = X_IDLE;
        endcase

        // a result aimed at pointer or flags lands there and wins
        if (we && wa == `WAP_IDX)
            rp_nxt = wd;
        else if (we && wa == `FLAGS_IDX)
            flags_nxt = wd;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (we && wa != `WAP_IDX && wa != `FLAGS_IDX)
            mem_r[wa] <= wd;
        if (!rstn)
        begin
            xs_r <= X_IDLE;
            op_r <= `OP_NOP;
            b1_r <= 8'h00;
            b2_r <= 8'h00;
            src_r <= 8'h00;
            dst_r <= 8'h00;
            sind_r <= 1'b0;
            dind_r <= 1'b0;
            sv_r <= 8'h00;
            dv_r <= 8'h00;
            dp_r <= 9'h000;
            rp_r <= `WAP_RST;
            flags_r <= `FLAGS_RST;
            stop_r <= 1'b0;
            bad_r <= 1'b0;
            unfl_r <= 1'b0;
            prev_nop_r <= 1'b0;
            sclk_en_r <= 1'b1;
            osc_en_r <= 1'b1;
            restart_pc_r <= `RESTART_PC;
            pend_r <= 1'b0;
            bwr_r <= 1'b0;
            bok_r <= 1'b0;
            bidx_r <= 10'h000;
            hrdata_r <= 32'h0000_0000;
            hready_r <= 1'b1;
        end
        else
        begin
            xs_r <= xs_nxt;
            op_r <= op_nxt;
            b1_r <= b1_nxt;
            b2_r <= b2_nxt;
            src_r <= src_nxt;
            dst_r <= dst_nxt;
            sind_r <= sind_nxt;
            dind_r <= dind_nxt;
            sv_r <= sv_nxt;
            dv_r <= dv_nxt;
            dp_r <= dp_nxt;
            rp_r <= rp_nxt;
            flags_r <= flags_nxt;
            stop_r <= stop_nxt;
            bad_r <= bad_nxt;
            unfl_r <= unfl_nxt;
            prev_nop_r <= prev_nop_nxt;
            sclk_en_r <= sclk_en_nxt;
            osc_en_r <= osc_en_nxt;
            restart_pc_r <= restart_pc_nxt;
            pend_r <= pend_nxt;
            bwr_r <= bwr_nxt;
            bok_r <= bok_nxt;
            bidx_r <= bidx_nxt;
            hrdata_r <= hrdata_nxt;
            hready_r <= hready_nxt;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp = 1'b0;
    assign sclk_en = sclk_en_r;
    assign osc_en = osc_en_r;
    assign restart_pc = restart_pc_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    ptr_load_a: assert property (
        xs_r == X_DEC && op_r == `OP_PTR_LOAD
        |=> rp_r == $past(b1_r) && $stable(flags_r))
        else $error("pointer load wrong or flags moved");
    stop_entry_a: assert property (
        xs_r == X_DEC && op_r == `OP_STOP
        |=> !sclk_en_r && !osc_en_r && stop_r)
        else $error("stop did not halt clocks");
    stop_hold_a: assert property (
        stop_r |=> stop_r && !sclk_en_r && restart_pc_r == `RESTART_PC)
        else $error("stop left without reset");
    sub_carry_a: assert property (
        xs_r == X_EXEC && al.op == ALU_SUB && dp_r != `FLAGS_IDX
        |=> flags_r[`FLG_C] == ($past(dv_r) < $past(sv_r)))
        else $error("subtract carry wrong");
    sub_zero_a: assert property (
        xs_r == X_EXEC && al.op == ALU_SUB && dp_r != `FLAGS_IDX
        |=> flags_r[`FLG_Z] == ($past(dv_r) == $past(sv_r)))
        else $error("subtract zero wrong");
    sub_overflow_a: assert property (
        xs_r == X_EXEC && al.op == ALU_SUB && dp_r != `FLAGS_IDX
        |=> flags_r[`FLG_V] == ($past(dv_r[7]) != $past(sv_r[7]) &&
            $past(sub_diff[7]) == $past(sv_r[7])))
        else $error("subtract overflow wrong");
    sub_sign_a: assert property (
        xs_r == X_EXEC && al.op == ALU_SUB && dp_r != `FLAGS_IDX
        |=> flags_r[`FLG_D] && flags_r[`FLG_S] == $past(sub_diff[7]))
        else $error("subtract sign or decimal wrong");
    sub_half_a: assert property (
        xs_r == X_EXEC && al.op == ALU_SUB && dp_r != `FLAGS_IDX
        |=> flags_r[`FLG_H] == ($past(dv_r[3:0]) < $past(sv_r[3:0])))
        else $error("subtract half carry wrong");
    swap_flags_a: assert property (
        xs_r == X_EXEC && al.op == ALU_SWAP && dp_r != `FLAGS_IDX
        |=> flags_r[`FLG_C] == $past(flags_r[`FLG_C]) &&
            flags_r[`FLG_H] == $past(flags_r[`FLG_H]) &&
            flags_r[`FLG_S] == $past(dv_r[3]))
        else $error("swap flags wrong");
    swap_write_a: assert property (
        xs_r == X_EXEC && al.op == ALU_SWAP
        |-> we && wd == {dv_r[3:0], dv_r[7:4]} && wa == dp_r)
        else $error("swap result wrong");
    group_map_a: assert property (
        xs_r == X_DST && dst_r[7:4] == `WORK_NIB && rp_r[3:0] == 4'h0
        |-> mp.phys == {1'b0, rp_r[7:4], dst_r[3:0]})
        else $error("working group mapping wrong");
    bank_map_a: assert property (
        xs_r == X_DST && dst_r[7:4] == `WORK_NIB && rp_r[3:0] != 4'h0
        |-> mp.phys[8] && mp.phys[3:0] == dst_r[3:0])
        else $error("bank mapping wrong");

endmodule : exec_core

// [tb/subtract_swap_pointer_stop_bench.sv]
// bench for exec_core: bus tasks, command sequences, expected values
// assumes: exec_core with one wait state, more while the executer is busy, indexes from core_consts.svh
`timescale 1ns/1ns
`include "core_consts.svh"

module subtract_swap_pointer_stop_bench
    import core_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic sclk_en;
    logic osc_en;
    logic [15:0] restart_pc;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [15:0] e;
    logic [7:0] cases [4][2] = '{'{8'h2A, 8'h03}, '{8'h05, 8'h05},
                                 '{8'h80, 8'h01}, '{8'h16, 8'h20}};

    exec_core u_exec_core
    (
        .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sclk_en(sclk_en), .osc_en(osc_en),
        .restart_pc(restart_pc)
    );

    always #10 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    // a hang is cut short well beyond the longest sequence
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [9:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0_0000, idx, 2'b00};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] t;
        bus(1'b1, idx, {24'h00_0000, d}, t);
    endtask : wr

    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] t;
        bus(1'b0, idx, 32'h0000_0000, t);
        chk(t, exp);
    endtask : rdc

    task automatic cmd(input logic [7:0] op, b1, b2);
        logic [31:0] t;
        bus(1'b1, `CMD_IDX, {8'h00, b2, b1, op}, t);
    endtask : cmd

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
    endtask : do_reset

    // expected {flags, result} of dst minus src, seen as borrows
    function automatic logic [15:0] sub_exp(input logic [7:0] d, s);
        logic [7:0] r;
        logic [7:0] f;
        int sd;
        r = d - s;
        sd = int'($signed(d)) - int'($signed(s));
        f = 8'h00;
        f[`FLG_C] = (d < s);
        f[`FLG_Z] = (d == s);
        f[`FLG_S] = r[7];
        f[`FLG_V] = (sd > 127) || (sd < -128);
        f[`FLG_D] = 1'b1;
        f[`FLG_H] = (d[3:0] < s[3:0]);
        return {f, r};
    endfunction : sub_exp

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        do_reset();
        chk({30'h0, sclk_en, osc_en}, 32'h0000_0003);
        chk({16'h0000, restart_pc}, 32'h0000_000C);
        chk({31'h0, hresp}, 32'h0000_0000);
        rdc(`WAP_IDX, 32'h0000_0000);
        rdc(10'h3FF, 32'h0000_0000);
        foreach (cases[i])
        begin
            e = sub_exp(cases[i][0], cases[i][1]);
            wr(10'h040, cases[i][0]);
            cmd(`OP_SUB_FIM, 8'h40, cases[i][1]);
            rdc(10'h040, {24'h0, e[7:0]});
            rdc(`FLAGS_IDX, {24'h0, e[15:8]});
        end
        cmd(`OP_PTR_LOAD, 8'hF0, 8'h00);
        rdc(`WAP_IDX, 32'h0000_00F0);
        rdc(`FLAGS_IDX, {24'h0, e[15:8]});
        wr(10'h0F3, 8'h16);
        wr(10'h0FB, 8'h20);
        cmd(`OP_SUB_RR, 8'h3B, 8'h00);
        e = sub_exp(8'h16, 8'h20);
        rdc(10'h0F3, {24'h0, e[7:0]});
        rdc(10'h0FB, 32'h0000_0020);
        rdc(`FLAGS_IDX, {24'h0, e[15:8]});
        wr(10'h012, 8'h1B);
        wr(10'h034, 8'h2E);
        cmd(`OP_SUB_FF, 8'h12, 8'h34);
        rdc(10'h034, 32'h0000_0013);
        rdc(10'h012, 32'h0000_001B);
        // indirect source and indirect destination forms
        wr(10'h0FF, 8'h16);
        wr(10'h0FA, 8'h20);
        wr(10'h020, 8'h11);
        cmd(`OP_SUB_RIR, 8'hFA, 8'h00);
        e = sub_exp(8'h16, 8'h11);
        rdc(10'h0FF, {24'h0, e[7:0]});
        rdc(`FLAGS_IDX, {24'h0, e[15:8]});
        wr(10'h0F3, 8'h10);
        wr(10'h010, 8'h01);
        wr(10'h04B, 8'h82);
        cmd(`OP_SUB_FIF, 8'hE3, 8'h4B);
        rdc(10'h04B, 32'h0000_0081);
        wr(10'h05F, 8'h4C);
        wr(10'h0D4, 8'h5F);
        cmd(`OP_SUB_IIM, 8'hD4, 8'h02);
        rdc(10'h05F, 32'h0000_004A);
        rdc(10'h0D4, 32'h0000_005F);
        // bank F: working registers move to the expanded bank
        wr(10'h005, 8'h77);
        cmd(`OP_PTR_LOAD, 8'h0F, 8'h00);
        wr(10'h1E0, 8'h50);
        wr(10'h1E1, 8'h20);
        cmd(`OP_SUB_FF, 8'hE1, 8'hE0);
        rdc(10'h1E0, 32'h0000_0030);
        wr(10'h1E5, 8'h09);
        cmd(`OP_SUB_FIM, 8'h05, 8'h01);
        rdc(10'h1E5, 32'h0000_0008);
        rdc(10'h005, 32'h0000_0077);
        // swap keeps C D H and V, sets Z and S from the result
        wr(`FLAGS_IDX, 8'h8C);
        wr(10'h0BC, 8'h0F);
        cmd(`OP_SWAP_R, 8'hBC, 8'h00);
        rdc(10'h0BC, 32'h0000_00F0);
        rdc(`FLAGS_IDX, 32'h0000_00AC);
        wr(10'h1E5, 8'hBC);
        cmd(`OP_SWAP_IR, 8'hE5, 8'h00);
        rdc(10'h0BC, 32'h0000_000F);
        rdc(`FLAGS_IDX, 32'h0000_008C);
        // an unknown opcode is reported, the next command clears it
        cmd(8'h00, 8'h00, 8'h00);
        rdc(`STAT_IDX, 32'h0000_0001 << `STAT_BAD);
        // stop, then a command that must be ignored, then reset
        cmd(`OP_NOP, 8'h00, 8'h00);
        cmd(`OP_STOP, 8'h00, 8'h00);
        repeat (2) @(posedge core_clk);
        chk({30'h0, sclk_en, osc_en}, 32'h0000_0000);
        rdc(`STAT_IDX, 32'h0000_0001 << `STAT_STOP);
        cmd(`OP_SUB_FIM, 8'hBC, 8'h01);
        rdc(10'h0BC, 32'h0000_000F);
        chk({30'h0, sclk_en, osc_en}, 32'h0000_0000);
        do_reset();
        chk({30'h0, sclk_en, osc_en}, 32'h0000_0003);
        chk({16'h0000, restart_pc}, 32'h0000_000C);
        rdc(`STAT_IDX, 32'h0000_0000);
        // stop with no flush ahead of it is flagged
        cmd(`OP_STOP, 8'h00, 8'h00);
        rdc(`STAT_IDX, 32'h0000_0005);
        finish_test();
    end

endmodule : subtract_swap_pointer_stop_bench
